// >>> pkg/dfud_pkg.sv
/*
  constants for the firmware-upgrade functional descriptor and detach block:
  apb register map, descriptor layout, reset values and timing counts.
  assumes a 125 MHz pclk.
*/
`default_nettype none
package dfud_pkg;
  // descriptor bytes
  localparam logic [7:0]  DESC_LEN        = 8'h09;
  localparam logic [7:0]  DESC_TYPE       = 8'h21;
  localparam int          DESC_BYTES      = 9;
  localparam logic [3:0]  OFS_LEN         = 4'h0;
  localparam logic [3:0]  OFS_TYPE        = 4'h1;
  localparam logic [3:0]  OFS_ATTR        = 4'h2;
  localparam logic [3:0]  OFS_TMO_LO      = 4'h3;
  localparam logic [3:0]  OFS_TMO_HI      = 4'h4;
  localparam logic [3:0]  OFS_XFER_LO     = 4'h5;
  localparam logic [3:0]  OFS_XFER_HI     = 4'h6;
  localparam logic [3:0]  OFS_VER_LO      = 4'h7;
  localparam logic [3:0]  OFS_VER_HI      = 4'h8;
  // attribute bits
  localparam int          ATTR_DNLOAD     = 0;
  localparam int          ATTR_UPLOAD     = 1;
  localparam int          ATTR_MANIF      = 2;
  localparam int          ATTR_DETACH     = 3;
  localparam int          ATTR_ACCEL      = 7;
  localparam logic [7:0]  ATTR_MASK       = 8'h8f;
  localparam logic [15:0] ACCEL_XFER      = 16'h1000;
  // reset values
  localparam logic [7:0]  ATTR_RST        = 8'h00;
  localparam logic [15:0] TMO_RST         = 16'h00ff;
  localparam logic [15:0] XFER_RST        = 16'h0400;
  localparam logic [15:0] VER_RST         = 16'h011a;
  // apb map
  localparam logic [7:0]  REG_ATTR        = 8'h00;
  localparam logic [7:0]  REG_TMO         = 8'h04;
  localparam logic [7:0]  REG_XFER        = 8'h08;
  localparam logic [7:0]  REG_VER         = 8'h0c;
  localparam logic [7:0]  REG_CMD         = 8'h10;
  localparam logic [7:0]  REG_STAT        = 8'h14;
  localparam logic [7:0]  REG_DESC0       = 8'h18;
  localparam logic [7:0]  REG_DESC1       = 8'h1c;
  localparam logic [7:0]  REG_DESC2       = 8'h20;
  localparam int          CMD_DETACH      = 0;
  localparam int          CMD_ENTER_DFU   = 1;
  localparam int          CMD_LEAVE_DFU   = 2;
  // timing
  localparam int          CLK_HZ          = 125_000_000;
  localparam int          TICK_MS         = 1;
  localparam int          TICK_CYC        = CLK_HZ / 1000 * TICK_MS;
  localparam int          DETACH_NS       = 10_000_000;
  localparam int          DETACH_CYC      = DETACH_NS / 8;
  localparam int          RESET_NS        = 10_000_000;
  localparam int          RESET_CYC       = RESET_NS / 8;
  typedef enum logic [2:0] {
    ST_RUN      = 3'b000,
    ST_WAIT     = 3'b001,
    ST_DETACHED = 3'b010,
    ST_BUSRST   = 3'b011,
    ST_DFU      = 3'b100
  } dfud_state_t;
endpackage
`default_nettype wire

// >>> design/dfud_top.sv
/*
  firmware-upgrade functional descriptor source and detach/reconfiguration
  controller, apb slave. assumes usb_reset_in and cable_in are async pins
  and the usb core reads the descriptor bytes by index on the same clock.
*/
// The implementer's own choices: the register addresses and the APB register port.
`default_nettype none
module dfud_top #(
  parameter int TICK_CYCLES   = dfud_pkg::TICK_CYC,
  parameter int DETACH_CYCLES = dfud_pkg::DETACH_CYC,
  parameter int RESET_CYCLES  = dfud_pkg::RESET_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        detach_req,
  input  wire logic [15:0] detach_host_tmo,
  input  wire logic        usb_reset_in,
  input  wire logic        cable_in,
  input  wire logic [3:0]  desc_index,
  output logic [7:0]       desc_byte,
  output logic             dfu_mode,
  output logic             bus_detach,
  output logic             bus_reset_drive
);
  if (TICK_CYCLES < 1 || DETACH_CYCLES < 1 || RESET_CYCLES < 1) begin : g_bad_cfg
    $error("dfud_top: cycle counts must be at least one");
  end

  // pin synchronisers
  logic [1:0] rst_sync_r;
  logic [1:0] cab_sync_r;
  logic       cab_prev_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_sync_r <= 2'b00;
      cab_sync_r <= 2'b00;
      cab_prev_r <= 1'b0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], usb_reset_in};
      cab_sync_r <= {cab_sync_r[0], cable_in};
      cab_prev_r <= cab_sync_r[1];
    end
  end
  logic usb_rst;
  logic cable_rise;
  assign usb_rst    = rst_sync_r[1];
  assign cable_rise = cab_sync_r[1] & ~cab_prev_r;

  // registers
  logic [7:0]  attr_r, attr_nxt;
  logic [15:0] tmo_r, tmo_nxt;
  logic [15:0] xfer_r, xfer_nxt;
  logic [15:0] ver_r, ver_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic        cmd_detach, cmd_enter, cmd_leave;
  logic        wr, rd;
  logic [15:0] tmo_eff;
  dfud_pkg::dfud_state_t st_r, st_nxt;

  // descriptor byte mux shared by usb core and apb readback
  function automatic logic [7:0] desc_at(input logic [3:0] i, input logic [7:0] a,
                                         input logic [15:0] t, input logic [15:0] x,
                                         input logic [15:0] v);
    logic [7:0] b;
    b = 8'h00;
    case (i)
      dfud_pkg::OFS_LEN:     b = dfud_pkg::DESC_LEN;
      dfud_pkg::OFS_TYPE:    b = dfud_pkg::DESC_TYPE;
      dfud_pkg::OFS_ATTR:    b = a;
      dfud_pkg::OFS_TMO_LO:  b = t[7:0];
      dfud_pkg::OFS_TMO_HI:  b = t[15:8];
      dfud_pkg::OFS_XFER_LO: b = x[7:0];
      dfud_pkg::OFS_XFER_HI: b = x[15:8];
      dfud_pkg::OFS_VER_LO:  b = v[7:0];
      dfud_pkg::OFS_VER_HI:  b = v[15:8];
      default:               b = 8'h00;
    endcase
    return b;
  endfunction

  // accelerated upload fixes the transfer size the host sees
  logic [15:0] xfer_eff;
  assign xfer_eff = attr_r[dfud_pkg::ATTR_ACCEL] ? dfud_pkg::ACCEL_XFER : xfer_r;

  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;

  always_comb begin
    attr_nxt    = attr_r;
    tmo_nxt     = tmo_r;
    xfer_nxt    = xfer_r;
    ver_nxt     = ver_r;
    cmd_detach  = 1'b0;
    cmd_enter   = 1'b0;
    cmd_leave   = 1'b0;
    prdata_nxt  = prdata_r;
    pready_nxt  = psel & ~penable;
    pslverr_nxt = 1'b0;
    if (psel & ~penable) begin
      case (paddr)
        dfud_pkg::REG_ATTR, dfud_pkg::REG_TMO, dfud_pkg::REG_XFER, dfud_pkg::REG_VER,
        dfud_pkg::REG_CMD, dfud_pkg::REG_STAT, dfud_pkg::REG_DESC0,
        dfud_pkg::REG_DESC1, dfud_pkg::REG_DESC2: pslverr_nxt = 1'b0;
        default:                                    pslverr_nxt = 1'b1;
      endcase
    end
    if (wr & pready_r & ~pslverr_r) begin
      case (paddr)
        // reserved bits 6:4 forced to zero
        dfud_pkg::REG_ATTR: attr_nxt = pwdata[7:0] & dfud_pkg::ATTR_MASK;
        dfud_pkg::REG_TMO:  tmo_nxt  = pwdata[15:0];
        dfud_pkg::REG_XFER: xfer_nxt = pwdata[15:0];
        dfud_pkg::REG_VER:  ver_nxt  = pwdata[15:0];
        dfud_pkg::REG_CMD: begin
          cmd_detach = pwdata[dfud_pkg::CMD_DETACH];
          cmd_enter  = pwdata[dfud_pkg::CMD_ENTER_DFU];
          cmd_leave  = pwdata[dfud_pkg::CMD_LEAVE_DFU];
        end
        default: attr_nxt = attr_r;
      endcase
    end
    if (rd) begin
      case (paddr)
        dfud_pkg::REG_ATTR:  prdata_nxt = {24'h000000, attr_r};
        dfud_pkg::REG_TMO:   prdata_nxt = {16'h0000, tmo_r};
        dfud_pkg::REG_XFER:  prdata_nxt = {16'h0000, xfer_eff};
        dfud_pkg::REG_VER:   prdata_nxt = {16'h0000, ver_r};
        dfud_pkg::REG_STAT:  prdata_nxt = {28'h0000000, bus_reset_drive, bus_detach,
                                           dfu_mode, st_r != dfud_pkg::ST_RUN &&
                                           st_r != dfud_pkg::ST_DFU};
        dfud_pkg::REG_DESC0: prdata_nxt = {desc_at(4'h3, attr_r, tmo_r, xfer_eff, ver_r),
                                           desc_at(4'h2, attr_r, tmo_r, xfer_eff, ver_r),
                                           dfud_pkg::DESC_TYPE, dfud_pkg::DESC_LEN};
        dfud_pkg::REG_DESC1: prdata_nxt = {ver_r[7:0], xfer_eff, tmo_r[15:8]};
        dfud_pkg::REG_DESC2: prdata_nxt = {24'h000000, ver_r[15:8]};
        default:             prdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      attr_r    <= dfud_pkg::ATTR_RST;
      tmo_r     <= dfud_pkg::TMO_RST;
      xfer_r    <= dfud_pkg::XFER_RST;
      ver_r     <= dfud_pkg::VER_RST;
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      attr_r    <= attr_nxt;
      tmo_r     <= tmo_nxt;
      xfer_r    <= xfer_nxt;
      ver_r     <= ver_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign prdata  = prdata_r;

  // reconfiguration controller
  logic [31:0] tick_r, tick_nxt;
  logic [15:0] ms_r, ms_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [15:0] lim_r, lim_nxt;
  logic [7:0]  desc_r, desc_nxt;
  logic        dfu_r, dfu_nxt, det_r, det_nxt, drv_r, drv_nxt;
  logic        detach_ev;

  assign detach_ev = detach_req | cmd_detach;
  // the host may only shorten the wait; its value is stale outside the request pulse
  assign tmo_eff = (detach_req && detach_host_tmo != 16'h0000 && detach_host_tmo < tmo_r)
                   ? detach_host_tmo : tmo_r;

  always_comb begin
    st_nxt   = st_r;
    tick_nxt = tick_r;
    ms_nxt   = ms_r;
    cnt_nxt  = cnt_r;
    lim_nxt  = lim_r;
    case (st_r)
      dfud_pkg::ST_RUN: begin
        if (detach_ev & ~cmd_enter) begin
          st_nxt   = attr_r[dfud_pkg::ATTR_DETACH] ? dfud_pkg::ST_DETACHED
                                                   : dfud_pkg::ST_WAIT;
          tick_nxt = 32'd0;
          ms_nxt   = 16'd0;
          cnt_nxt  = 32'd0;
          lim_nxt  = tmo_eff;
        end
        if (usb_rst & cmd_enter) begin
          st_nxt = dfud_pkg::ST_DFU;
        end
        if (cable_rise) begin
          st_nxt = dfud_pkg::ST_DFU;
        end
      end
      dfud_pkg::ST_WAIT: begin
        if (tick_r == 32'(TICK_CYCLES - 1)) begin
          tick_nxt = 32'd0;
          ms_nxt   = ms_r + 16'd1;
        end else begin
          tick_nxt = tick_r + 32'd1;
        end
        if (usb_rst) begin
          st_nxt = dfud_pkg::ST_DFU;
        end else if (cmd_enter) begin
          st_nxt  = dfud_pkg::ST_BUSRST;
          cnt_nxt = 32'd0;
        end else if (ms_r >= lim_r) begin
          st_nxt = dfud_pkg::ST_RUN;
        end
      end
      dfud_pkg::ST_DETACHED: begin
        // no host reset is expected here; the re-attach itself starts upgrade mode
        cnt_nxt = cnt_r + 32'd1;
        if (cnt_r == 32'(DETACH_CYCLES - 1)) begin
          st_nxt = dfud_pkg::ST_DFU;
        end
      end
      dfud_pkg::ST_BUSRST: begin
        cnt_nxt = cnt_r + 32'd1;
        if (cnt_r == 32'(RESET_CYCLES - 1)) begin
          st_nxt = dfud_pkg::ST_DFU;
        end
      end
      dfud_pkg::ST_DFU: begin
        if (cmd_leave) begin
          st_nxt = dfud_pkg::ST_RUN;
        end
      end
      default: st_nxt = dfud_pkg::ST_RUN;
    endcase
    dfu_nxt  = (st_nxt == dfud_pkg::ST_DFU);
    det_nxt  = (st_nxt == dfud_pkg::ST_DETACHED);
    drv_nxt  = (st_nxt == dfud_pkg::ST_BUSRST);
    // same bytes in both descriptor sets: no mode term in the mux
    desc_nxt = desc_at(desc_index, attr_r, tmo_r, xfer_eff, ver_r);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r   <= dfud_pkg::ST_RUN;
      tick_r <= 32'd0;
      ms_r   <= 16'd0;
      cnt_r  <= 32'd0;
      lim_r  <= 16'd0;
      desc_r <= 8'h00;
      dfu_r  <= 1'b0;
      det_r  <= 1'b0;
      drv_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      tick_r <= tick_nxt;
      ms_r   <= ms_nxt;
      cnt_r  <= cnt_nxt;
      lim_r  <= lim_nxt;
      desc_r <= desc_nxt;
      dfu_r  <= dfu_nxt;
      det_r  <= det_nxt;
      drv_r  <= drv_nxt;
    end
  end
  assign desc_byte       = desc_r;
  assign dfu_mode        = dfu_r;
  assign bus_detach      = det_r;
  assign bus_reset_drive = drv_r;

  // checks
  len_byte_a: assert property (@(posedge pclk) disable iff (!presetn)
    desc_index == dfud_pkg::OFS_LEN |=> desc_byte == dfud_pkg::DESC_LEN)
    else $error("length byte wrong");
  type_byte_a: assert property (@(posedge pclk) disable iff (!presetn)
    desc_index == dfud_pkg::OFS_TYPE |=> desc_byte == dfud_pkg::DESC_TYPE)
    else $error("type byte wrong");
  attr_rsvd_a: assert property (@(posedge pclk) disable iff (!presetn)
    attr_r[6:4] == 3'b000)
    else $error("reserved attribute bits set");
  attr_byte_a: assert property (@(posedge pclk) disable iff (!presetn)
    desc_index == dfud_pkg::OFS_ATTR |=> desc_byte == $past(attr_r))
    else $error("attribute byte mismatch");
  wait_tmo_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == dfud_pkg::ST_WAIT && ms_r >= lim_r && !usb_rst && !cmd_enter
    |=> st_r == dfud_pkg::ST_RUN)
    else $error("detach wait did not time out");
  wait_lim_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == dfud_pkg::ST_RUN && detach_ev && !cmd_enter && !cable_rise
    |=> lim_r <= $past(tmo_r))
    else $error("timeout above descriptor maximum");
  wait_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == dfud_pkg::ST_RUN ##1 st_r == dfud_pkg::ST_WAIT |-> ms_r == 16'd0)
    else $error("timer not cleared");
  rst_dfu_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == dfud_pkg::ST_WAIT && usb_rst |=> st_r == dfud_pkg::ST_DFU ##1 dfu_mode)
    else $error("reset did not enter upgrade mode");
  self_det_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == dfud_pkg::ST_RUN && detach_ev && !cmd_enter && !cable_rise &&
    attr_r[dfud_pkg::ATTR_DETACH] |=> ##1 bus_detach)
    else $error("no self detach");
  cable_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == dfud_pkg::ST_RUN && cable_rise |=> st_r == dfud_pkg::ST_DFU)
    else $error("cable plug did not enter upgrade mode");
  wait_c: cover property (@(posedge pclk) st_r == dfud_pkg::ST_WAIT ##1
    st_r == dfud_pkg::ST_RUN);
  dfu_c: cover property (@(posedge pclk) st_r == dfud_pkg::ST_WAIT ##1
    st_r == dfud_pkg::ST_DFU);
  drv_c: cover property (@(posedge pclk) bus_reset_drive ##1 !bus_reset_drive);
endmodule
`default_nettype wire

// >>> testbench/dfud_host_model.sv
/*
  usb host model on the default control endpoint: detach request pulse,
  bus reset pin, cable pin and descriptor byte index.
  assumes the block samples every pin on the rising edge of pclk.
*/
`default_nettype none
module dfud_host_model (
  input  wire logic        pclk,
  input  wire logic [7:0]  desc_byte,
  output logic             detach_req,
  output logic [15:0]      detach_host_tmo,
  output logic             usb_reset_in,
  output logic             cable_in,
  output logic [3:0]       desc_index
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    detach_req      = 1'b0;
    usb_reset_in    = 1'b0;
    cable_in        = 1'b0;
    desc_index      = 4'h0;
  end
  // the timeout field is only valid with the pulse, so it is scrambled after
  task automatic detach(input logic [15:0] tmo);
    @(posedge pclk);
    detach_req      <= 1'b1;
    detach_host_tmo <= tmo;
    @(posedge pclk);
    detach_req      <= 1'b0;
    detach_host_tmo <= ~tmo;
  endtask
  // not used after a self-detach, the device re-attaches itself then
  task automatic bus_reset(input int n);
    @(posedge pclk);
    usb_reset_in <= 1'b1;
    repeat (n) @(posedge pclk);
    usb_reset_in <= 1'b0;
  endtask
  task automatic plug(input logic v);
    @(posedge pclk);
    cable_in <= v;
  endtask
  task automatic get_byte(input logic [3:0] i, output logic [7:0] b);
    @(posedge pclk);
    desc_index <= i;
    repeat (2) @(posedge pclk);
    b = desc_byte;
  endtask
endmodule
`default_nettype wire

// >>> testbench/dfu_functional_descriptor_detach_tb_top.sv
/*
  self-checking bench: apb register rows, descriptor bytes, detach
  timeout, usb and self-generated reset, self-detach, cable entry.
  assumes short tick/detach/reset counts given as parameters.
*/
`default_nettype none
module dfu_functional_descriptor_detach_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [7:0]  a;
    logic        w;
    logic [31:0] d;
    logic [31:0] r;
    logic        e;
  } dfud_row_t;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready, pslverr, dfu_mode, bus_detach, bus_reset_drive;
  logic [31:0] prdata, rd;
  logic        detach_req, usb_reset_in, cable_in, er;
  logic [15:0] detach_host_tmo;
  logic [3:0]  desc_index;
  logic [7:0]  desc_byte, b;
  int          fail_count = 0;
  int          cmp_count = 0;
  dfud_row_t   rows [16] = '{
    '{8'h00, 1'b0, 32'h0, 32'h00000000, 1'b0}, '{8'h04, 1'b0, 32'h0, 32'h000000ff, 1'b0},
    '{8'h08, 1'b0, 32'h0, 32'h00000400, 1'b0}, '{8'h0c, 1'b0, 32'h0, 32'h0000011a, 1'b0},
    '{8'h14, 1'b0, 32'h0, 32'h00000000, 1'b0}, '{8'h18, 1'b0, 32'h0, 32'hff002109, 1'b0},
    '{8'h1c, 1'b0, 32'h0, 32'h1a040000, 1'b0}, '{8'h20, 1'b0, 32'h0, 32'h00000001, 1'b0},
    '{8'h40, 1'b0, 32'h0, 32'h00000000, 1'b1}, '{8'h40, 1'b1, 32'hffffffff, 32'h0, 1'b1},
    '{8'h00, 1'b1, 32'hff, 32'h0, 1'b0},       '{8'h00, 1'b0, 32'h0, 32'h0000008f, 1'b0},
    '{8'h08, 1'b0, 32'h0, 32'h00001000, 1'b0}, '{8'h00, 1'b1, 32'h07, 32'h0, 1'b0},
    '{8'h04, 1'b1, 32'h03, 32'h0, 1'b0},       '{8'h18, 1'b0, 32'h0, 32'h03072109, 1'b0}};
  logic [7:0]  eb [10] = '{dfud_pkg::DESC_LEN, dfud_pkg::DESC_TYPE, 8'h07, 8'h03, 8'h00,
                           8'h00, 8'h04, 8'h1a, 8'h01, 8'h00};
  logic [15:0] ht [2] = '{16'h0002, 16'h0009};
  int          s1 [2] = '{12, 22};
  int          s2 [2] = '{14, 16};

  always #4 pclk = ~pclk;

  dfud_top #(.TICK_CYCLES(10), .DETACH_CYCLES(5), .RESET_CYCLES(5)) u_dfud_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .detach_req(detach_req), .detach_host_tmo(detach_host_tmo),
    .usb_reset_in(usb_reset_in), .cable_in(cable_in), .desc_index(desc_index),
    .desc_byte(desc_byte), .dfu_mode(dfu_mode), .bus_detach(bus_detach),
    .bus_reset_drive(bus_reset_drive));

  dfud_host_model u_dfud_host_model (
    .pclk(pclk), .desc_byte(desc_byte), .detach_req(detach_req),
    .detach_host_tmo(detach_host_tmo), .usb_reset_in(usb_reset_in),
    .cable_in(cable_in), .desc_index(desc_index));

  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask

  // request held from setup until the edge that samples pready high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      chk(32'h0, 32'h1);
      test_done();
    end
  endtask

  // 0 upgrade mode, 1 self-detach, 2 self-generated reset
  task automatic wait_pin(input int s, input logic v);
    int   n;
    logic cur;
    for (n = 0; n < 40; n++) begin
      @(posedge pclk);
      cur = (s == 0) ? dfu_mode : (s == 1) ? bus_detach : bus_reset_drive;
      if (cur === v) break;
    end
    chk({31'h0, cur}, {31'h0, v});
    if (cur !== v) test_done();
  endtask

  task automatic all_quiet();
    chk(prdata, 32'h0);
    chk({19'h0, desc_byte, pready, pslverr, dfu_mode, bus_detach, bus_reset_drive}, 32'h0);
  endtask

  task automatic desc_all();
    for (int i = 0; i < 10; i++) begin
      u_dfud_host_model.get_byte(4'(i), b);
      chk({24'h0, b}, {24'h0, eb[i]});
    end
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    all_quiet();
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d, rd, er);
      if (!rows[i].w) chk(rd, rows[i].r);
      chk({31'h0, er}, {31'h0, rows[i].e});
    end
    desc_all();
    // shorter host timeout wins, longer one is capped by the descriptor
    for (int k = 0; k < 2; k++) begin
      u_dfud_host_model.detach(ht[k]);
      repeat (s1[k]) @(posedge pclk);
      apb(dfud_pkg::REG_STAT, 1'b0, 32'h0, rd, er);
      chk(rd, 32'h1);
      repeat (s2[k]) @(posedge pclk);
      apb(dfud_pkg::REG_STAT, 1'b0, 32'h0, rd, er);
      chk(rd, 32'h0);
    end
    u_dfud_host_model.detach(16'h0000);
    u_dfud_host_model.bus_reset(4);
    wait_pin(0, 1'b1);
    desc_all();
    apb(dfud_pkg::REG_CMD, 1'b1, 32'h4, rd, er);
    wait_pin(0, 1'b0);
    apb(dfud_pkg::REG_CMD, 1'b1, 32'h1, rd, er);
    apb(dfud_pkg::REG_CMD, 1'b1, 32'h2, rd, er);
    wait_pin(2, 1'b1);
    wait_pin(0, 1'b1);
    apb(dfud_pkg::REG_CMD, 1'b1, 32'h4, rd, er);
    wait_pin(0, 1'b0);
    apb(dfud_pkg::REG_ATTR, 1'b1, 32'h0f, rd, er);
    u_dfud_host_model.detach(16'h0000);
    wait_pin(1, 1'b1);
    wait_pin(0, 1'b1);
    apb(dfud_pkg::REG_CMD, 1'b1, 32'h4, rd, er);
    wait_pin(0, 1'b0);
    // enter command lands while the synchronised bus reset is high
    fork
      u_dfud_host_model.bus_reset(8);
      begin
        repeat (3) @(posedge pclk);
        apb(dfud_pkg::REG_CMD, 1'b1, 32'h2, rd, er);
      end
    join
    wait_pin(0, 1'b1);
    apb(dfud_pkg::REG_CMD, 1'b1, 32'h4, rd, er);
    wait_pin(0, 1'b0);
    u_dfud_host_model.plug(1'b1);
    wait_pin(0, 1'b1);
    u_dfud_host_model.plug(1'b0);
    repeat (3) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    all_quiet();
    presetn <= 1'b1;
    apb(dfud_pkg::REG_ATTR, 1'b0, 32'h0, rd, er);
    chk(rd, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
